// File: hw/ubl_pkg.sv
package ubl_pkg;

   // =====================================================================
   // Register indices; byte address is four times the index.
   localparam logic [11:0] UART1_MODE_IDX = 12'h20C;
   localparam logic [11:0] UART1_STAT_IDX = 12'h20E;
   localparam logic [11:0] UART1_TXD_IDX  = 12'h210;
   localparam logic [11:0] UART1_RXD_IDX  = 12'h212;
   localparam logic [11:0] UART1_BRG_IDX  = 12'h214;
   localparam logic [11:0] UART2_MODE_IDX = 12'h216;
   localparam logic [11:0] UART2_STAT_IDX = 12'h218;
   localparam logic [11:0] UART2_TXD_IDX  = 12'h21A;
   localparam logic [11:0] UART2_RXD_IDX  = 12'h21C;
   localparam logic [11:0] UART2_BRG_IDX  = 12'h21E;
   // Interrupt registers: status, clear, enable at base, base+1, base+2.
   localparam logic [11:0] UART1_IRQ_IDX  = 12'h230;
   localparam logic [11:0] UART2_IRQ_IDX  = 12'h238;

   // =====================================================================
   // Reset values and writable masks.
   localparam logic [15:0] MODE_RESET  = 16'h0000;
   localparam logic [15:0] STAT_RESET  = 16'h0110;
   localparam logic [15:0] BRG_RESET   = 16'h0000;
   localparam logic [15:0] MODE_WMASK  = 16'hA0E7;

   // =====================================================================
   // Status bit positions.
   localparam int STAT_TXISEL = 15;
   localparam int STAT_BRK    = 11;
   localparam int STAT_TXEN   = 10;
   localparam int STAT_RXISEL = 6;
   localparam int STAT_ADDEN  = 5;
   localparam int STAT_OERR   = 1;

   // =====================================================================
   // Interrupt bits and oversampling.
   localparam int          IRQ_W      = 3;
   localparam int          IRQ_RX     = 0;
   localparam int          IRQ_TX     = 1;
   localparam int          IRQ_OVR    = 2;
   localparam logic [3:0]  OS_LAST    = 4'hF;
   localparam logic [3:0]  OS_MID     = 4'h7;

   // =====================================================================
   // Mode control layout.
   typedef struct packed {
      logic       module_enable;
      logic       rsv14;
      logic       stop_in_idle;
      logic [4:0] rsv12;
      logic       wake_enable;
      logic       loopback_enable;
      logic       autobaud_capture_link;
      logic [1:0] rsv4;
      logic [1:0] data_select;
      logic       two_stop;
   } ubl_mode_t;

   typedef enum {TX_IDLE, TX_START, TX_DATA, TX_STOP} ubl_tx_state_t;
   typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} ubl_rx_state_t;

endpackage : ubl_pkg

// File: hw/ubl_sync.sv
// =====================================================================
// Two flip-flop synchroniser for one level.
module ubl_sync
   import ubl_pkg::*;
(
   // Clock and reset.
   input  wire logic clock,
   input  wire logic rst,
   // Level in and out.
   input  wire logic d_in,
   output logic      d_out
);
   logic meta_reg;
   logic sync_reg;

   // Both stages reset to the idle line level.
   always_ff @(posedge clock) begin
      if (rst) begin
         meta_reg <= 1'b1;
         sync_reg <= 1'b1;
      end else begin
         meta_reg <= d_in;
         sync_reg <= meta_reg;
      end
   end

   assign d_out = sync_reg;
endmodule : ubl_sync

// File: hw/ubl_baud.sv
// =====================================================================
// Divisor counter giving one oversampling tick per divisor+1 clocks.
module ubl_baud
   import ubl_pkg::*;
#(
   parameter int WIDTH = 16
)
(
   // Clock and reset.
   input  wire logic             clock,
   input  wire logic             rst,
   // Control.
   input  wire logic             run,
   input  wire logic [WIDTH-1:0] divisor,
   // Tick out.
   output logic                  tick
);
   logic [WIDTH-1:0] cnt_reg;
   logic [WIDTH-1:0] cnt_next;

   if (WIDTH < 1) begin : g_chk
      $error("ubl_baud: WIDTH must be at least one.");
   end

   // Reload on wrap, count down once per clock; stopped clocks sit at zero.
   always_comb begin
      cnt_next = cnt_reg;
      if (!run) begin
         cnt_next = '0;
      end else if (cnt_reg == '0) begin
         cnt_next = divisor;
      end else begin
         cnt_next = cnt_reg - 1'b1;
      end
   end

   // Counter register.
   always_ff @(posedge clock) begin
      if (rst) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign tick = run && (cnt_reg == '0);
endmodule : ubl_baud

// File: hw/ubl_uart.sv
module ubl_uart
   import ubl_pkg::*;
#(
   parameter int CHANNEL = 1
)
(
   // Clock and reset.
   input  wire logic        clock,
   input  wire logic        rst,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [15:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Power state from the device.
   input  wire logic        sleep_req,
   input  wire logic        idle_req,
   // Serial pins.
   input  wire logic        serial_in_pin,
   output logic             serial_out_pin,
   // Capture link and interrupt.
   output logic             autobaud_capture_link,
   output logic             irq
);
   if (CHANNEL != 1 && CHANNEL != 2) begin : g_chk
      $error("ubl_uart: CHANNEL must be 1 or 2.");
   end

   // =====================================================================
   // Address decode.
   localparam logic [11:0] MODE_IDX = (CHANNEL == 1) ? UART1_MODE_IDX : UART2_MODE_IDX;
   localparam logic [11:0] STAT_IDX = (CHANNEL == 1) ? UART1_STAT_IDX : UART2_STAT_IDX;
   localparam logic [11:0] TXD_IDX  = (CHANNEL == 1) ? UART1_TXD_IDX  : UART2_TXD_IDX;
   localparam logic [11:0] RXD_IDX  = (CHANNEL == 1) ? UART1_RXD_IDX  : UART2_RXD_IDX;
   localparam logic [11:0] BRG_IDX  = (CHANNEL == 1) ? UART1_BRG_IDX  : UART2_BRG_IDX;
   localparam logic [11:0] IRQ_IDX  = (CHANNEL == 1) ? UART1_IRQ_IDX  : UART2_IRQ_IDX;

   logic [11:0] idx;
   logic        wr_acc;
   logic        rd_acc;
   assign idx    = paddr[13:2];
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;

   // =====================================================================
   // Shared state and signals.
   ubl_mode_t         mode_reg, mode_next;
   logic [15:0]       ctl_reg, ctl_next;
   logic [15:0]       brg_reg, brg_next;
   logic [8:0]        txh_reg, txh_next;
   logic              txf_reg, txf_next;
   logic [7:0]        rxd_reg, rxd_next;
   logic              rxa_reg, rxa_next;
   logic              ferr_reg, ferr_next;
   logic [IRQ_W-1:0]  ist_reg, ist_next;
   logic [IRQ_W-1:0]  ien_reg, ien_next;
   logic [31:0]       prd_reg, prd_next;
   logic              perr_reg, perr_next;
   logic              abl_reg, rx_prev_reg;

   logic rx_sync, tick, halt, run, rx_src, rx_fall;
   logic tx_load, rx_done, rx_bad;

   // Transmitter and receiver state, declared here because the register file reads it.
   ubl_tx_state_t     tx_state_reg, tx_state_next;
   logic [3:0]        tx_os_reg, tx_os_next;
   logic [2:0]        tx_bit_reg, tx_bit_next;
   logic [7:0]        tx_sh_reg, tx_sh_next;
   logic              tx_line_reg, tx_line_next;
   logic              tx_busy;
   ubl_rx_state_t     rx_state_reg, rx_state_next;
   logic [3:0]        rx_os_reg, rx_os_next;
   logic [2:0]        rx_bit_reg, rx_bit_next;
   logic [7:0]        rx_sh_reg, rx_sh_next;

   ubl_sync u_sync (
      .clock (clock),
      .rst   (rst),
      .d_in  (serial_in_pin),
      .d_out (rx_sync)
   );

   // Sleep stops the baud tick, transmitter and receiver; idle stops them only with stop-in-idle set.
   assign halt = sleep_req || (idle_req && mode_reg.stop_in_idle);
   assign run  = mode_reg.module_enable && !halt;

   ubl_baud #(.WIDTH(16)) u_baud (
      .clock   (clock),
      .rst     (rst),
      .run     (run),
      .divisor (brg_reg),
      .tick    (tick)
   );

   // =====================================================================
   // Register file and interrupts.
   always_comb begin
      mode_next = mode_reg;
      ctl_next  = ctl_reg;
      brg_next  = brg_reg;
      txh_next  = txh_reg;
      txf_next  = txf_reg && !tx_load;
      rxd_next  = rxd_reg;
      rxa_next  = rxa_reg;
      ferr_next = ferr_reg;
      ist_next  = ist_reg;
      ien_next  = ien_reg;
      prd_next  = prd_reg;
      perr_next = perr_reg;
      // Setup phase latches read data and the error answer.
      if (psel && !penable) begin
         perr_next = 1'b0;
         prd_next  = 32'h0000_0000;
         case (idx)
            MODE_IDX: prd_next[15:0] = mode_reg;
            STAT_IDX: prd_next[15:0] = {ctl_reg[15:9], !txf_reg && !tx_busy,
                                         ctl_reg[7:5], rx_state_reg == RX_IDLE,
                                         1'b0, ferr_reg, ctl_reg[1], rxa_reg};
            RXD_IDX:  prd_next[15:0] = {8'h00, rxd_reg};
            BRG_IDX:  prd_next[15:0] = brg_reg;
            IRQ_IDX:  prd_next[IRQ_W-1:0] = ist_reg;
            IRQ_IDX + 12'h002: prd_next[IRQ_W-1:0] = ien_reg;
            TXD_IDX, IRQ_IDX + 12'h001: prd_next = 32'h0000_0000;
            default:  perr_next = 1'b1;
         endcase
      end
      // Reading the receive word frees the holding register.
      if (rd_acc && idx == RXD_IDX) begin
         rxa_next = 1'b0;
      end
      if (wr_acc) begin
         case (idx)
            MODE_IDX: mode_next = pwdata[15:0] & MODE_WMASK;
            STAT_IDX: begin
               ctl_next[STAT_TXISEL] = pwdata[STAT_TXISEL];
               ctl_next[STAT_BRK]    = pwdata[STAT_BRK];
               ctl_next[STAT_TXEN]   = pwdata[STAT_TXEN];
               ctl_next[STAT_RXISEL +: 2] = pwdata[STAT_RXISEL +: 2];
               ctl_next[STAT_ADDEN]  = pwdata[STAT_ADDEN];
               ctl_next[STAT_OERR]   = ctl_reg[STAT_OERR] && pwdata[STAT_OERR];
            end
            TXD_IDX: begin
               if (!txf_reg || tx_load) begin
                  txh_next = pwdata[8:0];
                  txf_next = 1'b1;
               end
            end
            BRG_IDX: brg_next = pwdata[15:0];
            IRQ_IDX + 12'h001: ist_next = ist_reg & ~pwdata[IRQ_W-1:0];
            IRQ_IDX + 12'h002: ien_next = pwdata[IRQ_W-1:0];
            default: ;
         endcase
      end
      // Completed frames; a full holding register turns them into overrun.
      if (rx_done) begin
         if (rxa_next) begin
            ctl_next[STAT_OERR] = 1'b1;
            ist_next[IRQ_OVR]   = 1'b1;
         end else begin
            rxd_next  = rx_sh_reg;
            rxa_next  = 1'b1;
            ferr_next = rx_bad;
            if (!ctl_reg[STAT_RXISEL + 1]) begin
               ist_next[IRQ_RX] = 1'b1;
            end
         end
      end
      // Wake edge in sleep raises the receive interrupt.
      if (sleep_req && mode_reg.wake_enable && mode_reg.module_enable && rx_fall) begin
         ist_next[IRQ_RX] = 1'b1;
      end
      if (tx_load) begin
         ist_next[IRQ_TX] = 1'b1;
      end
      ctl_next[9] = txf_next;
   end

   // Register file storage; sleep has no effect here.
   always_ff @(posedge clock) begin
      if (rst) begin
         mode_reg <= MODE_RESET;
         ctl_reg  <= STAT_RESET;
         brg_reg  <= BRG_RESET;
         txh_reg  <= '0;
         txf_reg  <= 1'b0;
         rxd_reg  <= '0;
         rxa_reg  <= 1'b0;
         ferr_reg <= 1'b0;
         ist_reg  <= '0;
         ien_reg  <= '0;
         prd_reg  <= '0;
         perr_reg <= 1'b0;
      end else begin
         mode_reg <= mode_next;
         ctl_reg  <= ctl_next;
         brg_reg  <= brg_next;
         txh_reg  <= txh_next;
         txf_reg  <= txf_next;
         rxd_reg  <= rxd_next;
         rxa_reg  <= rxa_next;
         ferr_reg <= ferr_next;
         ist_reg  <= ist_next;
         ien_reg  <= ien_next;
         prd_reg  <= prd_next;
         perr_reg <= perr_next;
      end
   end

   assign prdata  = prd_reg;
   assign pslverr = perr_reg;
   assign pready  = 1'b1;
   assign irq     = |(ist_reg & ien_reg);

   // =====================================================================
   // Transmitter.
   assign tx_busy = tx_state_reg != TX_IDLE;
   assign tx_load = run && tick && !tx_busy && txf_reg && ctl_reg[STAT_TXEN];

   always_comb begin
      tx_state_next = tx_state_reg;
      tx_os_next    = tx_os_reg;
      tx_bit_next   = tx_bit_reg;
      tx_sh_next    = tx_sh_reg;
      tx_line_next  = tx_line_reg;
      if (sleep_req) begin
         tx_state_next = TX_IDLE;
         tx_line_next  = 1'b1;
      end else if (run && tick) begin
         tx_os_next = tx_os_reg + 4'h1;
         case (tx_state_reg)
            TX_IDLE: begin
               tx_line_next = 1'b1;
               if (tx_load) begin
                  tx_sh_next    = txh_reg[7:0];
                  tx_os_next    = 4'h0;
                  tx_state_next = TX_START;
                  tx_line_next  = 1'b0;
               end
            end
            TX_START: if (tx_os_reg == OS_LAST) begin
               tx_state_next = TX_DATA;
               tx_bit_next   = 3'h0;
               tx_line_next  = tx_sh_reg[0];
            end
            TX_DATA: if (tx_os_reg == OS_LAST) begin
               tx_sh_next  = {1'b1, tx_sh_reg[7:1]};
               tx_bit_next = tx_bit_reg + 3'h1;
               tx_line_next = tx_sh_reg[1];
               if (tx_bit_reg == 3'h7) begin
                  tx_state_next = TX_STOP;
                  tx_bit_next   = {2'b00, mode_reg.two_stop};
                  tx_line_next  = 1'b1;
               end
            end
            TX_STOP: if (tx_os_reg == OS_LAST) begin
               tx_bit_next = tx_bit_reg - 3'h1;
               if (tx_bit_reg == 3'h0) begin
                  tx_state_next = TX_IDLE;
               end
            end
            default: tx_state_next = TX_IDLE;
         endcase
      end else if (!mode_reg.module_enable) begin
         tx_state_next = TX_IDLE;
         tx_line_next  = 1'b1;
      end
      // Break holds the line low only while the block runs; sleep or disable forces it high, stop-in-idle holds it.
      if (ctl_reg[STAT_BRK] && run) begin
         tx_line_next = 1'b0;
      end
   end

   // Transmit registers.
   always_ff @(posedge clock) begin
      if (rst) begin
         tx_state_reg <= TX_IDLE;
         tx_os_reg    <= '0;
         tx_bit_reg   <= '0;
         tx_sh_reg    <= '0;
         tx_line_reg  <= 1'b1;
      end else begin
         tx_state_reg <= tx_state_next;
         tx_os_reg    <= tx_os_next;
         tx_bit_reg   <= tx_bit_next;
         tx_sh_reg    <= tx_sh_next;
         tx_line_reg  <= tx_line_next;
      end
   end

   // The pin always follows the transmitter, loopback or not.
   assign serial_out_pin = tx_line_reg;

   // =====================================================================
   // Receiver.
   // Loopback takes the receiver off the pin and onto the transmitter.
   assign rx_src  = mode_reg.loopback_enable ? tx_line_reg : rx_sync;
   assign rx_fall = rx_prev_reg && !rx_sync;

   always_comb begin
      rx_state_next = rx_state_reg;
      rx_os_next    = rx_os_reg;
      rx_bit_next   = rx_bit_reg;
      rx_sh_next    = rx_sh_reg;
      rx_done       = 1'b0;
      rx_bad        = 1'b0;
      if (sleep_req || !mode_reg.module_enable) begin
         rx_state_next = RX_IDLE;
      end else if (run && tick) begin
         rx_os_next = rx_os_reg + 4'h1;
         case (rx_state_reg)
            RX_IDLE: if (!rx_src) begin
               rx_state_next = RX_START;
               rx_os_next    = 4'h0;
            end
            RX_START: if (rx_os_reg == OS_MID) begin
               rx_os_next    = 4'h0;
               rx_bit_next   = 3'h0;
               rx_state_next = rx_src ? RX_IDLE : RX_DATA;
            end
            RX_DATA: if (rx_os_reg == OS_LAST) begin
               rx_sh_next  = {rx_src, rx_sh_reg[7:1]};
               rx_bit_next = rx_bit_reg + 3'h1;
               if (rx_bit_reg == 3'h7) begin
                  rx_state_next = RX_STOP;
               end
            end
            RX_STOP: if (rx_os_reg == OS_LAST) begin
               rx_done       = 1'b1;
               rx_bad        = !rx_src;
               rx_state_next = RX_IDLE;
            end
            default: rx_state_next = RX_IDLE;
         endcase
      end
   end

   // Receive registers, edge history and capture link.
   always_ff @(posedge clock) begin
      if (rst) begin
         rx_state_reg <= RX_IDLE;
         rx_os_reg    <= '0;
         rx_bit_reg   <= '0;
         rx_sh_reg    <= '0;
         rx_prev_reg  <= 1'b1;
         abl_reg      <= 1'b1;
      end else begin
         rx_state_reg <= rx_state_next;
         rx_os_reg    <= rx_os_next;
         rx_bit_reg   <= rx_bit_next;
         rx_sh_reg    <= rx_sh_next;
         rx_prev_reg  <= rx_sync;
         abl_reg      <= mode_reg.autobaud_capture_link ? rx_sync : 1'b1;
      end
   end

   assign autobaud_capture_link = abl_reg;

   // =====================================================================
   // Checks.
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   logic [15:0] gap_reg;
   logic        gap_ok_reg;
   always_ff @(posedge clock) begin
      if (rst || !run || (wr_acc && idx == BRG_IDX)) begin
         gap_reg    <= '0;
         gap_ok_reg <= 1'b0;
      end else if (tick) begin
         gap_reg    <= '0;
         gap_ok_reg <= 1'b1;
      end else begin
         gap_reg    <= gap_reg + 16'h0001;
      end
   end

   sequence sleep_entry_s;
      !sleep_req ##1 sleep_req;
   endsequence

   loop_route_a: assert property (mode_reg.loopback_enable && run && tick
         && rx_state_reg == RX_IDLE && !serial_out_pin |=> rx_state_reg == RX_START)
      else $error("Loopback does not feed the receiver.");
   pin_cut_a: assert property (mode_reg.loopback_enable && run && rx_state_reg == RX_IDLE
         && serial_out_pin && tick |=> rx_state_reg == RX_IDLE)
      else $error("Receive pin reached the receiver in loopback.");
   tx_start_a: assert property (tx_load && !ctl_reg[STAT_BRK] |=> !serial_out_pin)
      else $error("Start bit missing on the transmit pin.");
   brg_write_a: assert property (wr_acc && idx == BRG_IDX
         |=> brg_reg == $past(pwdata[15:0]))
      else $error("Divisor write not stored.");
   tick_gap_a: assert property (tick && gap_ok_reg |-> gap_reg == brg_reg)
      else $error("Tick spacing differs from divisor plus one.");
   cap_link_a: assert property (mode_reg.autobaud_capture_link
         |=> autobaud_capture_link == $past(rx_sync))
      else $error("Capture link does not follow receive input.");
   clk_stop_a: assert property (sleep_req |-> !tick)
      else $error("Tick seen during sleep.");
   sleep_tx_a: assert property (sleep_entry_s |=> serial_out_pin && tx_state_reg == TX_IDLE)
      else $error("Transmit not aborted high on sleep.");
   sleep_rx_a: assert property (sleep_entry_s |=> rx_state_reg == RX_IDLE)
      else $error("Reception not aborted on sleep.");
   sleep_keep_a: assert property (sleep_req && !wr_acc |=> $stable(brg_reg) && $stable(mode_reg))
      else $error("Sleep changed a register.");
   wake_irq_a: assert property (sleep_req && mode_reg.wake_enable && mode_reg.module_enable
         && rx_fall |=> ist_reg[IRQ_RX])
      else $error("Wake edge did not raise receive interrupt.");
   wake_off_a: assert property (!mode_reg.module_enable && !ist_reg[IRQ_RX] && !wr_acc
         |=> !ist_reg[IRQ_RX])
      else $error("Receive interrupt while module disabled.");
   idle_halt_a: assert property (idle_req && mode_reg.stop_in_idle && !sleep_req
         |=> $stable(tx_state_reg) && $stable(rx_os_reg))
      else $error("Block ran in idle with stop-in-idle set.");
endmodule : ubl_uart

// File: testbench/ubl_remote.sv
// =====================================================================
// Remote serial node: drives the receive line of the block, idle high.
module ubl_remote (
   // Clock.
   input  wire logic clock,
   // Line towards the block.
   output logic      line
);
   timeunit 1ns;
   timeprecision 100ps;

   // The line idles high between frames.
   initial line = 1'b1;

   // Holds the line at a fixed level from the next edge on.
   task jam(input logic v);
      @(posedge clock);
      line <= v;
   endtask : jam

   // Sends one 8N1 frame, least significant bit first, bitc clocks a bit.
   task send(input logic [7:0] d, input int bitc);
      logic [9:0] f;
      f = {1'b1, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clock);
         line <= f[i];
         repeat (bitc - 1) @(posedge clock);
      end
   endtask : send
endmodule : ubl_remote

// File: testbench/ubl_uart_tb.sv
// =====================================================================
// Self-checking bench for one channel of the serial block.
module ubl_uart_tb
   import ubl_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic        clock, rst, psel, penable, pwrite, pready, pslverr, err;
   logic        sleep_req, idle_req, rx_pin, serial_out_pin, link, irq;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int          fails, num_checks, n;

   ubl_uart ubl_uart_i (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sleep_req(sleep_req), .idle_req(idle_req), .serial_in_pin(rx_pin),
      .serial_out_pin(serial_out_pin), .autobaud_capture_link(link), .irq(irq));
   ubl_remote ubl_remote_i (.clock(clock), .line(rx_pin));

   // =====================================================================
   // Shared tasks.
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // One APB transfer; read data and error are taken at the pready edge.
   task apb(input logic wr, input logic [11:0] idx, input logic [15:0] wd);
      @(posedge clock);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= {2'h0, idx, 2'h0};
      pwdata  <= {16'h0000, wd};
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task cyc(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask : cyc

   // Divisor first, then mode with format, then transmit enable.
   task cfg(input logic [15:0] mode);
      apb(1'b1, UART1_BRG_IDX, 16'h0001);
      apb(1'b1, UART1_MODE_IDX, mode);
      apb(1'b1, UART1_STAT_IDX, 16'h0400);
      apb(1'b1, UART1_IRQ_IDX + 12'h001, 16'h0007);
      apb(1'b1, UART1_IRQ_IDX + 12'h002, 16'h0001);
   endtask : cfg

   // =====================================================================
   // Scenarios.
   task t_regs;
      apb(1'b0, UART1_STAT_IDX, 16'h0000);
      chk("status reset", rd, 32'h0000_0110);
      apb(1'b1, UART1_BRG_IDX, 16'hFFFF);
      apb(1'b0, UART1_BRG_IDX, 16'h0000);
      chk("divisor", rd, 32'h0000_FFFF);
      apb(1'b0, 12'h220, 16'h0000);
      chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
   endtask : t_regs

   // Receive pin held low must not disturb the looped frame.
   task t_loop;
      cfg(16'h8040);
      ubl_remote_i.jam(1'b0);
      apb(1'b1, UART1_TXD_IDX, 16'h00A5);
      n = 0;
      while (serial_out_pin !== 1'b0) cyc(1);
      while (serial_out_pin === 1'b0) begin
         n++;
         cyc(1);
      end
      chk("start bit clocks", n, 32'd32);
      while (irq !== 1'b1) cyc(1);
      apb(1'b0, UART1_RXD_IDX, 16'h0000);
      chk("looped data", rd, 32'h0000_00A5);
      ubl_remote_i.jam(1'b1);
   endtask : t_loop

   task t_rx;
      cfg(16'h8020);
      fork
         ubl_remote_i.send(8'h3C, 32);
         begin
            cyc(20);
            chk("capture link", {31'h0, link}, 32'h0);
         end
      join
      cyc(4);
      chk("capture idle", {31'h0, link}, 32'h1);
      while (irq !== 1'b1) cyc(1);
      apb(1'b0, UART1_RXD_IDX, 16'h0000);
      chk("received", rd, 32'h0000_003C);
   endtask : t_rx

   task t_sleep;
      cfg(16'h8040);
      apb(1'b1, UART1_TXD_IDX, 16'h0000);
      while (serial_out_pin !== 1'b0) cyc(1);
      cyc(60);
      @(posedge clock);
      sleep_req <= 1'b1;
      cyc(3);
      n = 0;
      repeat (64) begin
         if (serial_out_pin === 1'b1) n++;
         cyc(1);
      end
      chk("line high in sleep", n, 32'd64);
      @(posedge clock);
      sleep_req <= 1'b0;
      apb(1'b0, UART1_BRG_IDX, 16'h0000);
      chk("divisor kept", rd, 32'h0000_0001);
      apb(1'b0, UART1_MODE_IDX, 16'h0000);
      chk("mode kept", rd, 32'h0000_8040);
      apb(1'b0, UART1_STAT_IDX, 16'h0000);
      chk("rx aborted", rd, 32'h0000_0510);
   endtask : t_sleep

   // Stop-in-idle freezes a frame; clearing it lets the frame finish in idle.
   task t_idle;
      cfg(16'hA000);
      apb(1'b1, UART1_TXD_IDX, 16'h0000);
      while (serial_out_pin !== 1'b0) cyc(1);
      @(posedge clock);
      idle_req <= 1'b1;
      cyc(400);
      chk("frozen in idle", {31'h0, serial_out_pin}, 32'h0);
      apb(1'b1, UART1_MODE_IDX, 16'h8000);
      cyc(400);
      chk("runs in idle", {31'h0, serial_out_pin}, 32'h1);
      @(posedge clock);
      idle_req <= 1'b0;
   endtask : t_idle

   task t_wake;
      cfg(16'h8080);
      sleep_req <= 1'b1;
      ubl_remote_i.jam(1'b0);
      cyc(8);
      chk("wake irq", {31'h0, irq}, 32'h1);
      ubl_remote_i.jam(1'b1);
      sleep_req <= 1'b0;
      cfg(16'h0080);
      sleep_req <= 1'b1;
      ubl_remote_i.jam(1'b0);
      cyc(8);
      chk("no wake when off", {31'h0, irq}, 32'h0);
      ubl_remote_i.jam(1'b1);
      sleep_req <= 1'b0;
   endtask : t_wake

   task summarize;
      if (fails == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : summarize

   // =====================================================================
   // Clock, main sequence and watchdog.
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   initial begin
      {rst, psel, penable, pwrite, sleep_req, idle_req} = 6'h20;
      paddr = 16'h0000;
      pwdata = 32'h0000_0000;
      fails = 0;
      num_checks = 0;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      t_regs;
      t_loop;
      t_rx;
      t_sleep;
      t_idle;
      t_wake;
      summarize;
   end

   initial begin
      repeat (20000) @(posedge clock);
      fails++;
      summarize;
   end
endmodule : ubl_uart_tb
